/* hw/psiw_params.svh */
/*
 * Constants of the pulse sequencer instruction decoder: word layout,
 * timing counts and reset values.
 * Assumes it is included by bare name from hw/ files; holds definitions only.
 */
`ifndef PSIW_PARAMS_SVH
`define PSIW_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------
`define PSIW_WORD_W      80
`define PSIW_PAT_MSB     79
`define PSIW_PAT_LSB     56
`define PSIW_DATA_MSB    55
`define PSIW_DATA_LSB    36
`define PSIW_OP_MSB      35
`define PSIW_OP_LSB      32
`define PSIW_DLY_MSB     31
`define PSIW_DLY_LSB     0
`define PSIW_PAT_W       24
`define PSIW_DATA_W      20
`define PSIW_DLY_W       32

// ----------------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------------
`define PSIW_MIN_CYCLES  32'h0000_0005
`define PSIW_WAIT_EXTRA  32'h0000_0006
`define PSIW_ADDR_RST    16'h0000
`define PSIW_PAT_RST     24'h00_0000

`endif

/* hw/psiw_pkg.sv */
/*
 * Types shared by the pulse sequencer instruction decoder.
 * Assumes no surroundings beyond a SystemVerilog compiler.
 */
package psiw_pkg;

    typedef enum logic [3:0] {
        PSIW_OP_CONTINUE = 4'h0,
        PSIW_OP_STOP     = 4'h1,
        PSIW_OP_LOOP     = 4'h2,
        PSIW_OP_END_LOOP = 4'h3,
        PSIW_OP_SUB_CALL = 4'h4,
        PSIW_OP_SUB_RET  = 4'h5,
        PSIW_OP_BRANCH   = 4'h6,
        PSIW_OP_LONG_DLY = 4'h7,
        PSIW_OP_WAIT     = 4'h8
    } psiw_op_e;

    // Gray codes along idle -> fetch -> run -> wait -> tail -> stop.
    typedef enum logic [2:0] {
        PSIW_ST_IDLE  = 3'h0,
        PSIW_ST_FETCH = 3'h1,
        PSIW_ST_RUN   = 3'h3,
        PSIW_ST_WAIT  = 3'h2,
        PSIW_ST_TAIL  = 3'h6,
        PSIW_ST_STOP  = 3'h7
    } psiw_state_e;

endpackage

/* hw/psiw_line_sync.sv */
/*
 * Two-flop synchroniser with falling-edge detect for a low-true pin.
 * Assumes the pin is asynchronous to i_clk and idles high.
 */
`timescale 1ns/10ps
module psiw_line_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_line_n,
    output logic      o_low,
    output logic      o_fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic fall;
    } psiw_sync_s;

    psiw_sync_s st;
    psiw_sync_s next_st;

    always_comb begin
        next_st      = st;
        next_st.s1   = i_line_n;
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
        next_st.fall = st.prev & ~st.s2;
    end

    // Idle level of the pulled-up pin is high, so reset to one.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= 4'hE;
        end else begin
            st <= next_st;
        end
    end

    assign o_low  = ~st.s2;
    assign o_fall = st.fall;
endmodule

/* hw/psiw_core.sv */
/*
 * Instruction sequencer: fetches 80-bit words, drives the output pattern for
 * the programmed count, and follows the op code flow.
 * Assumes program memory answers combinationally on o_addr and the start and
 * restart lines are asynchronous low-true pins pulled up off chip.
 */
`timescale 1ns/10ps
`include "psiw_params.svh"

// Behaviour
// RULE_01 - Each 80-bit memory word is one instruction.
// RULE_02 - Word splits into 24-bit pattern, 20-bit data, 4-bit op, 32-bit delay.
// RULE_03 - The delay count sets how long the instruction executes.
// RULE_04 - Durations lie between five and two to the 32 minus one cycles.
// RULE_05 - The first 24 bits drive the 24 output lines; on a stop word the code keeps the previous pattern instead.
// RULE_06 - Outputs hold the pattern unchanged throughout the instruction.
// RULE_07 - The loader fills every field of every word in one format.
// RULE_08 - Start and restart lines are active low.
// RULE_09 - The reference clock is 50 MHz unless arranged otherwise.
// RULE_10 - The op code selects continue, stop, loops, calls, branch, long delay, wait.
// RULE_11 - Wait stalls for a trigger, then runs delay plus six cycles.
// RULE_12 - Stop halts at once, ignoring its delay.
// RULE_13 - Trigger fall while waiting resumes after wait, restarts at zero otherwise; the code ignores it during fetch and run.
// RULE_14 - Pattern 79:56, data 55:36, op 35:32, delay 31:0.
module psiw_core #(
    parameter int ADDR_W  = 16,
    parameter int DEPTH_W = 3
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic [`PSIW_WORD_W-1:0]    i_word,
    input  wire logic                       i_hw_start_line_n,
    input  wire logic                       i_hw_restart_line_n,
    output logic      [ADDR_W-1:0]          o_addr,
    output logic      [`PSIW_PAT_W-1:0]     o_pattern,
    output logic                            o_running,
    output logic                            o_waiting,
    output logic                            o_stopped,
    output logic                            o_resetting
);
    import psiw_pkg::*;

    localparam int DEPTH = 1 << DEPTH_W;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        psiw_state_e                            fsm;
        logic [ADDR_W-1:0]                      pc;
        logic [`PSIW_PAT_W-1:0]                 pat;
        logic [`PSIW_DLY_W-1:0]                 cnt;
        logic [`PSIW_DATA_W-1:0]                mult;
        logic [DEPTH-1:0][ADDR_W-1:0]           ret;
        logic [DEPTH_W-1:0]                     sp;
        logic [DEPTH-1:0][`PSIW_DATA_W-1:0]     loops;
        logic [DEPTH_W-1:0]                     lp;
        logic [ADDR_W-1:0]                      next_pc_hold;
        logic                                   loop_back;
        logic                                   run_f;
        logic                                   wait_f;
        logic                                   stop_f;
        logic                                   idle_f;
    } psiw_core_s;

    psiw_core_s st;
    psiw_core_s next_st;

    logic start_fall;
    logic restart_fall;
    logic restart_low;

    // RULE_08 low-true synchronisers
    psiw_line_sync u_start (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_line_n (i_hw_start_line_n),
        .o_low    (),
        .o_fall   (start_fall)
    );

    psiw_line_sync u_restart (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_line_n (i_hw_restart_line_n),
        .o_low    (restart_low),
        .o_fall   (restart_fall)
    );

    // RULE_14 field packing
    logic [`PSIW_PAT_W-1:0]  f_pat;
    logic [`PSIW_DATA_W-1:0] f_data;
    psiw_op_e                f_op;
    logic [`PSIW_DLY_W-1:0]  f_dly;
    // RULE_01 RULE_02 one word split
    assign f_pat  = i_word[`PSIW_PAT_MSB:`PSIW_PAT_LSB];
    assign f_data = i_word[`PSIW_DATA_MSB:`PSIW_DATA_LSB];
    assign f_op   = psiw_op_e'(i_word[`PSIW_OP_MSB:`PSIW_OP_LSB]);
    assign f_dly  = i_word[`PSIW_DLY_MSB:`PSIW_DLY_LSB];

    // Fetch spends one cycle, so the run phase counts the delay minus one.
    // A delay below the five-cycle floor is lifted to it.
    function automatic logic [`PSIW_DLY_W-1:0] run_len(input logic [`PSIW_DLY_W-1:0] d);
        logic [`PSIW_DLY_W-1:0] v;
        v = (d < `PSIW_MIN_CYCLES) ? `PSIW_MIN_CYCLES : d;
        return v - 32'h0000_0002;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        case (st.fsm)
            PSIW_ST_IDLE, PSIW_ST_STOP: begin
                // RULE_13 restart from zero
                if (start_fall) begin
                    next_st.pc  = `PSIW_ADDR_RST;
                    next_st.sp  = '0;
                    next_st.lp  = '0;
                    next_st.loop_back = 1'b0;
                    next_st.fsm = PSIW_ST_FETCH;
                end
            end
            PSIW_ST_FETCH: begin
                // RULE_05 RULE_06 pattern latched once per instruction
                next_st.pat  = f_pat;
                // RULE_03 RULE_04 delay timing
                next_st.cnt  = run_len(f_dly);
                next_st.mult = '0;
                next_st.next_pc_hold = st.pc + 1'b1;
                next_st.fsm  = PSIW_ST_RUN;
                next_st.loop_back = 1'b0;
                // RULE_10 op code flow
                case (f_op)
                    PSIW_OP_STOP: begin
                        // RULE_12 immediate halt
                        next_st.pat = st.pat;
                        next_st.fsm = PSIW_ST_STOP;
                    end
                    PSIW_OP_LOOP: begin
                        // A jump back lands on this word again, so the count loads once.
                        if (!st.loop_back) begin
                            next_st.loops[st.lp] = f_data;
                            next_st.lp = st.lp + 1'b1;
                        end
                    end
                    PSIW_OP_END_LOOP: begin
                        if (st.loops[st.lp - 1'b1] > 20'h0_0001) begin
                            next_st.loops[st.lp - 1'b1] = st.loops[st.lp - 1'b1] - 1'b1;
                            next_st.next_pc_hold = f_data[ADDR_W-1:0];
                            next_st.loop_back = 1'b1;
                        end else begin
                            next_st.lp = st.lp - 1'b1;
                        end
                    end
                    PSIW_OP_SUB_CALL: begin
                        next_st.ret[st.sp] = st.pc + 1'b1;
                        next_st.sp = st.sp + 1'b1;
                        next_st.next_pc_hold = f_data[ADDR_W-1:0];
                    end
                    PSIW_OP_SUB_RET: begin
                        next_st.sp = st.sp - 1'b1;
                        next_st.next_pc_hold = st.ret[st.sp - 1'b1];
                    end
                    PSIW_OP_BRANCH: next_st.next_pc_hold = f_data[ADDR_W-1:0];
                    PSIW_OP_LONG_DLY: begin
                        next_st.mult = f_data - 1'b1;
                    end
                    PSIW_OP_WAIT: begin
                        next_st.fsm = PSIW_ST_WAIT;
                    end
                    default: ;
                endcase
            end
            PSIW_ST_RUN: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - 1'b1;
                end else if (st.mult != '0) begin
                    next_st.mult = st.mult - 1'b1;
                    next_st.cnt  = run_len(f_dly) + 1'b1;
                end else begin
                    next_st.pc  = st.next_pc_hold;
                    next_st.fsm = PSIW_ST_FETCH;
                end
            end
            PSIW_ST_WAIT: begin
                // RULE_11 RULE_13 trigger resumes past the wait
                if (start_fall) begin
                    next_st.cnt = st.cnt + `PSIW_WAIT_EXTRA;
                    next_st.fsm = PSIW_ST_RUN;
                end
            end
            default: next_st.fsm = PSIW_ST_IDLE;
        endcase
        // RULE_08 restart line wins over everything
        if (restart_fall) begin
            next_st.fsm = PSIW_ST_IDLE;
            next_st.pc  = `PSIW_ADDR_RST;
            next_st.sp  = '0;
            next_st.lp  = '0;
            next_st.loop_back = 1'b0;
        end
        // Status flags are registered so the status pins come from flops.
        next_st.run_f  = (next_st.fsm == PSIW_ST_RUN) || (next_st.fsm == PSIW_ST_FETCH);
        next_st.wait_f = (next_st.fsm == PSIW_ST_WAIT);
        next_st.stop_f = (next_st.fsm == PSIW_ST_STOP);
        next_st.idle_f = (next_st.fsm == PSIW_ST_IDLE);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st        <= '0;
            st.fsm    <= PSIW_ST_IDLE;
            st.idle_f <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_addr      = st.pc;
    assign o_pattern   = st.pat;
    assign o_running   = st.run_f;
    assign o_waiting   = st.wait_f;
    assign o_stopped   = st.stop_f;
    assign o_resetting = st.idle_f;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_pat_hold;
        @(posedge i_clk) disable iff (i_rst)
        (st.fsm == PSIW_ST_RUN) && (next_st.fsm == PSIW_ST_RUN) |=> $stable(o_pattern);
    endproperty
    a_pat_hold: assert property (p_pat_hold) else $error("pattern changed mid instruction"); // RULE_06

    property p_pat_load;
        @(posedge i_clk) disable iff (i_rst)
        (st.fsm == PSIW_ST_FETCH) && (f_op != PSIW_OP_STOP) && !restart_fall
        |=> o_pattern == $past(f_pat);
    endproperty
    a_pat_load: assert property (p_pat_load) else $error("pattern not taken from word"); // RULE_05

    property p_stop_now;
        @(posedge i_clk) disable iff (i_rst)
        (st.fsm == PSIW_ST_FETCH) && (f_op == PSIW_OP_STOP) && !restart_fall |=> o_stopped;
    endproperty
    a_stop_now: assert property (p_stop_now) else $error("stop did not halt at once"); // RULE_12

    property p_wait_enter;
        @(posedge i_clk) disable iff (i_rst)
        (st.fsm == PSIW_ST_FETCH) && (f_op == PSIW_OP_WAIT) && !restart_fall |=> o_waiting;
    endproperty
    a_wait_enter: assert property (p_wait_enter) else $error("wait not entered"); // RULE_11

    property p_restart;
        @(posedge i_clk) disable iff (i_rst)
        restart_fall |=> o_resetting && (o_addr == `PSIW_ADDR_RST);
    endproperty
    a_restart: assert property (p_restart) else $error("restart line ignored"); // RULE_08

    property p_start;
        @(posedge i_clk) disable iff (i_rst)
        o_resetting && start_fall && !restart_fall |=> (st.fsm == PSIW_ST_FETCH) && o_addr == '0;
    endproperty
    a_start: assert property (p_start) else $error("start fall did not start at zero"); // RULE_13

    property p_min_len;
        @(posedge i_clk) disable iff (i_rst)
        $rose(st.fsm == PSIW_ST_RUN) && !restart_fall |=> o_running [*3];
    endproperty
    a_min_len: assert property (p_min_len) else $error("instruction shorter than floor"); // RULE_04

    property p_len;
        @(posedge i_clk) disable iff (i_rst)
        (st.fsm == PSIW_ST_FETCH) && (f_op == PSIW_OP_CONTINUE) && (f_dly == 32'h0000_0005)
        && !restart_fall && !restart_low ##1 !restart_fall [*5]
        |-> ##0 (st.fsm == PSIW_ST_FETCH);
    endproperty
    a_len: assert property (p_len) else $error("delay count not honoured"); // RULE_03

    c_stop:  cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_stopped));
    c_wait:  cover property (@(posedge i_clk) disable iff (i_rst) o_waiting ##1 o_running);
    c_call:  cover property (@(posedge i_clk) disable iff (i_rst)
                 (st.fsm == PSIW_ST_FETCH) && (f_op == PSIW_OP_SUB_CALL));
    c_loop:  cover property (@(posedge i_clk) disable iff (i_rst)
                 (st.fsm == PSIW_ST_FETCH) && (f_op == PSIW_OP_END_LOOP));
endmodule

/* tb/psiw_prog_mem.sv */
/*
 * Program memory model for the sequencer bench: 64 words of 80 bits.
 * Assumes the core reads it combinationally on its address output.
 */
`timescale 1ns/10ps
module psiw_prog_mem (
    input  wire logic [15:0] i_addr,
    output logic      [79:0] o_word
);
    // every field defined
    // A declaration value is set before the bench's loads, avoiding a time-zero race.
    logic [79:0] mem [0:63] = '{default: 80'h0};

    task automatic load(input int a, input logic [79:0] w);
        mem[a] = (w[31:0] < 32'h5) ? {w[79:32], 32'h5} : w;
    endtask

    assign o_word = mem[i_addr[5:0]];
endmodule

/* tb/pulse_sequencer_instr_word_test.sv */
/*
 * Self-checking bench for the sequencer core with a program memory model.
 * Assumes psiw_pkg is compiled first; pins idle high like a pulled-up line.
 */
`timescale 1ns/10ps
module pulse_sequencer_instr_word_test;
    import psiw_pkg::*;
    logic        i_clk;
    logic        i_rst;
    logic        start_n;
    logic        restart_n;
    logic [15:0] addr;
    logic [79:0] word;
    logic [23:0] pattern;
    logic        running;
    logic        waiting;
    logic        stopped;
    logic        resetting;
    int          errors;
    int          checks;

    psiw_core #(.ADDR_W(16), .DEPTH_W(3)) dut (
        .i_clk               (i_clk),
        .i_rst               (i_rst),
        .i_word              (word),
        .i_hw_start_line_n   (start_n),
        .i_hw_restart_line_n (restart_n),
        .o_addr              (addr),
        .o_pattern           (pattern),
        .o_running           (running),
        .o_waiting           (waiting),
        .o_stopped           (stopped),
        .o_resetting         (resetting)
    );

    psiw_prog_mem mem (.i_addr(addr), .o_word(word));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // word packing
    function automatic logic [79:0] mk(logic [23:0] p, logic [19:0] d, psiw_op_e op,
                                       logic [31:0] n);
        return {p, d, op, n};
    endfunction

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic fall(input bit line);
        @(posedge i_clk);
        if (line) restart_n <= 1'b0;
        else start_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        start_n   <= 1'b1;
        restart_n <= 1'b1;
        #1;
    endtask

    // Waits for a pattern, then counts how many cycles it stands.
    task automatic seg(input logic [23:0] pat, input int dur);
        int n;
        n = 0;
        while (pattern !== pat && n < 300) begin
            step();
            n++;
        end
        check("pattern", pattern, pat);
        n = 0;
        while (pattern === pat && n < 300) begin
            step();
            n++;
        end
        check("duration", n, dur);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check("addr", addr, 32'h0);
        check("pattern", pattern, 32'h0);
        check("resetting", resetting, 32'h1);
        check("running", running, 32'h0);
    endtask

    // Walks every flow op: loop twice, call, return, long delay, branch.
    task automatic t_flow();
        fall(0);
        seg(24'h000001, 5);
        seg(24'h000002, 6);
        seg(24'h000003, 6);
        seg(24'h000002, 6);
        seg(24'h000003, 6);
        seg(24'h000004, 6);
        seg(24'h000007, 6);
        seg(24'h000005, 18);
        seg(24'h000006, 6);
    endtask

    task automatic t_wait();
        int n;
        repeat (3) step();
        check("waiting", waiting, 32'h1);
        repeat (20) step();
        check("held", pattern, 32'h0000A8);
        fall(0);
        n = 4;
        while (pattern === 24'h0000A8 && n < 100) begin
            step();
            n++;
        end
        // Delay six plus six fixed, with pin sync slack.
        check("exit window", (n >= 12 && n <= 22), 32'h1);
        check("wait left", waiting, 32'h0);
    endtask

    task automatic t_stop();
        int n;
        n = 0;
        while (stopped !== 1'b1 && n < 40) begin
            step();
            n++;
        end
        check("stop at", (n >= 5 && n <= 8), 32'h1);
        repeat (60) step();
        check("stop pat", pattern, 32'h0000B9);
        check("stop run", running, 32'h0);
    endtask

    task automatic t_restart();
        fall(1);
        repeat (3) step();
        check("resetting", resetting, 32'h1);
        check("addr", addr, 32'h0);
        check("stopped", stopped, 32'h0);
        fall(0);
        seg(24'h000001, 5);
        seg(24'h000002, 6);
        fall(1);
        repeat (3) step();
        check("abort", resetting, 32'h1);
        check("abort addr", addr, 32'h0);
        check("abort run", running, 32'h0);
    endtask

    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    // reference clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial begin
        #2000000;
        errors++;
        print_verdict();
    end

    initial begin
        i_rst     = 1'b1;
        start_n   = 1'b1;
        restart_n = 1'b1;
        errors    = 0;
        checks    = 0;
        mem.load(0, mk(24'h000001, 20'h0, PSIW_OP_CONTINUE, 32'h5));
        mem.load(1, mk(24'h000002, 20'h2, PSIW_OP_LOOP, 32'h6));
        mem.load(2, mk(24'h000003, 20'h1, PSIW_OP_END_LOOP, 32'h6));
        mem.load(3, mk(24'h000004, 20'h8, PSIW_OP_SUB_CALL, 32'h6));
        mem.load(4, mk(24'h000005, 20'h3, PSIW_OP_LONG_DLY, 32'h6));
        mem.load(5, mk(24'h000006, 20'h9, PSIW_OP_BRANCH, 32'h6));
        mem.load(8, mk(24'h000007, 20'h0, PSIW_OP_SUB_RET, 32'h6));
        mem.load(9, mk(24'h0000A8, 20'h0, PSIW_OP_WAIT, 32'h6));
        mem.load(10, mk(24'h0000B9, 20'h0, PSIW_OP_CONTINUE, 32'h6));
        mem.load(11, mk(24'h0000CA, 20'h0, PSIW_OP_STOP, 32'h32));
        repeat (8) @(posedge i_clk);
        #1;
        t_reset();
        @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) step();
        t_flow();
        t_wait();
        t_stop();
        t_restart();
        print_verdict();
    end
endmodule
